// ==== design/ofrd_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Address bit ten low selects normal registers; high selects test space.
// - Each of eight framer register sets is fully separate from the others.
// - Write data in unused bit positions changes no state.
// - Unused bits may read as either value; this design returns zero.
// - Every writable configuration bit reads back its last written value.
// - Reset clears every writable normal register bit to zero.
// - Writes to read-only locations leave operation unaffected.
// - Corresponding registers of successive framers sit 080H apart from 000H.
module ofrd_regs
  import ofrd_pkg::*;
(
  input  wire logic                  CORE_CLK,     // 10 MHz core clock
  input  wire logic                  SYS_RST,      // Sync reset, active high
  input  wire logic                  CLK_EN,       // Freezes all state when low
  input  wire logic                  HSEL,         // Slave select
  input  wire logic [31:0]           HADDR,        // Byte address
  input  wire logic [1:0]            HTRANS,       // Transfer type
  input  wire logic                  HWRITE,       // Write when high
  input  wire logic [2:0]            HSIZE,        // Transfer size
  input  wire logic [31:0]           HWDATA,       // Write data
  input  wire logic                  HREADY,       // Bus ready
  input  wire logic [NUM_FRAMERS*32-1:0] DET_PATTERN, // Detector bytes per framer
  input  wire logic [NUM_FRAMERS-1:0]    DET_EVENT,   // Per-framer status pulse
  output logic      [31:0]           HRDATA,       // Read data
  output logic                       HREADYOUT,    // Low for one wait state on each read
  output logic                       HRESP,        // Always OKAY
  output logic [NUM_FRAMERS*80-1:0]  CFG_OUT,      // Configuration per framer
  output logic                       TEST_HIT      // Last access hit test space
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  ofrd_cfg_t cfg [NUM_FRAMERS];
  ofrd_acc_t acc;
  logic [NUM_FRAMERS*32-1:0] det_s1;
  logic [NUM_FRAMERS*32-1:0] det_s2;
  logic [NUM_FRAMERS-1:0] evt_s1;
  logic [NUM_FRAMERS-1:0] evt_s2;
  logic [NUM_FRAMERS-1:0] evt_d;
  logic [ADDR_W-1:0] word_addr;
  logic next_valid;
  logic next_test;

  assign word_addr  = HADDR[ADDR_W+HADDR_IDX_LO-1:HADDR_IDX_LO];
  assign next_valid = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ) && (HSIZE == HSIZE_WORD);
  assign next_test  = word_addr[TEST_SEL_BIT];

  function automatic logic [7:0] det_byte(input logic [NUM_FRAMERS*32-1:0] v,
                                          input logic [2:0] f, input logic [1:0] b);
    det_byte = v[{f, b, 3'h0} +: 8];
  endfunction

  // ----------------------------------------------------------------
  // Synchronise detector inputs
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      det_s1 <= '0;
      det_s2 <= '0;
      evt_s1 <= '0;
      evt_s2 <= '0;
      evt_d  <= '0;
    end else if (CLK_EN) begin
      det_s1 <= DET_PATTERN;
      det_s2 <= det_s1;
      evt_s1 <= DET_EVENT;
      evt_s2 <= evt_s1;
      evt_d  <= evt_s2;
    end
  end

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      acc      <= '0;
      TEST_HIT <= 1'b0;
    end else if (CLK_EN) begin
      if (HREADY) begin
        acc.valid  <= next_valid && !next_test;
        acc.write  <= HWRITE;
        acc.framer <= word_addr[FRM_SEL_HI:FRM_SEL_LO];
        acc.offset <= word_addr[REG_SEL_HI:0];
        TEST_HIT   <= next_valid ? next_test : TEST_HIT;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-framer register sets
  // ----------------------------------------------------------------
  for (genvar f = 0; f < NUM_FRAMERS; f++) begin : g_frm
    logic hit_wr;
    assign hit_wr = acc.valid && acc.write && (acc.framer == 3'(f));

    always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
        cfg[f] <= '0;
      end else if (CLK_EN) begin
        if (hit_wr) begin
          unique case (acc.offset)
            OFS_BOC_CODE: cfg[f].boc_code <= HWDATA[7:0] & BOC_CODE_MASK;
            OFS_PAT_CTRL: cfg[f].ctrl     <= HWDATA[7:0];
            OFS_PAT_LEN:  cfg[f].len      <= HWDATA[7:0];
            OFS_PAT_TAP:  cfg[f].tap      <= HWDATA[7:0];
            OFS_PAT_ERR:  cfg[f].err      <= HWDATA[7:0];
            OFS_PAT_INS1: cfg[f].ins1     <= HWDATA[7:0];
            OFS_PAT_INS2: cfg[f].ins2     <= HWDATA[7:0];
            OFS_PAT_INS3: cfg[f].ins3     <= HWDATA[7:0];
            OFS_PAT_INS4: cfg[f].ins4     <= HWDATA[7:0];
            default: ;
          endcase
        end
        // Status bit: set wins over write-one-to-clear
        if (hit_wr && acc.offset == OFS_PAT_IRQ) begin
          cfg[f].irq[1:0] <= HWDATA[1:0] & IRQ_WR_MASK[1:0];
        end
        if (evt_s2[f] && !evt_d[f]) begin
          cfg[f].irq[7] <= 1'b1;
        end else if (hit_wr && acc.offset == OFS_PAT_IRQ && HWDATA[7]) begin
          cfg[f].irq[7] <= 1'b0;
        end
      end
    end

    always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
        CFG_OUT[f*80 +: 80] <= '0;
      end else if (CLK_EN) begin
        CFG_OUT[f*80 +: 80] <= cfg[f];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  logic [7:0] next_rd;
  always_comb begin
    next_rd = UNUSED_READ;
    unique case (acc.offset)
      OFS_BOC_CODE: next_rd = cfg[acc.framer].boc_code;
      OFS_PAT_CTRL: next_rd = cfg[acc.framer].ctrl;
      OFS_PAT_IRQ:  next_rd = cfg[acc.framer].irq;
      OFS_PAT_LEN:  next_rd = cfg[acc.framer].len;
      OFS_PAT_TAP:  next_rd = cfg[acc.framer].tap;
      OFS_PAT_ERR:  next_rd = cfg[acc.framer].err;
      OFS_PAT_INS1: next_rd = cfg[acc.framer].ins1;
      OFS_PAT_INS2: next_rd = cfg[acc.framer].ins2;
      OFS_PAT_INS3: next_rd = cfg[acc.framer].ins3;
      OFS_PAT_INS4: next_rd = cfg[acc.framer].ins4;
      OFS_PAT_DET1: next_rd = det_byte(det_s2, acc.framer, 2'h0);
      OFS_PAT_DET2: next_rd = det_byte(det_s2, acc.framer, 2'h1);
      OFS_PAT_DET3: next_rd = det_byte(det_s2, acc.framer, 2'h2);
      OFS_PAT_DET4: next_rd = det_byte(det_s2, acc.framer, 2'h3);
      default:      next_rd = UNUSED_READ;
    endcase
    if (!acc.valid || acc.write) begin
      next_rd = UNUSED_READ;
    end
  end

  // Read data is registered, so reads take one wait state
  logic rd_wait;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      HRDATA    <= '0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      rd_wait   <= 1'b0;
    end else if (CLK_EN) begin
      HRESP <= 1'b0;
      if (HREADY && next_valid && !HWRITE) begin
        HREADYOUT <= 1'b0;
        rd_wait   <= 1'b1;
      end else if (rd_wait) begin
        HRDATA    <= {24'h000000, next_rd};
        HREADYOUT <= 1'b1;
        rd_wait   <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TEST_NO_WRITE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && HREADY && next_valid && next_test) |=> !acc.valid)
    else $error("test space access decoded as normal");
  AST_RESET_CLEAR: assert property (@(posedge CORE_CLK)
    SYS_RST |=> (cfg[0] == '0 && cfg[7] == '0))
    else $error("config not cleared by reset");
  AST_ISOLATE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && acc.valid && acc.framer != 3'h3) |=> $stable(cfg[3].ctrl))
    else $error("other framer disturbed");
  AST_BOC_MASK: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    cfg[0].boc_code[7:6] == 2'h0)
    else $error("unused bits stored");
  AST_READBACK: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && acc.valid && acc.write && acc.framer == 3'h0 && acc.offset == OFS_PAT_LEN)
      |=> cfg[0].len == $past(HWDATA[7:0]))
    else $error("written value not held");
  AST_RO_SAFE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && acc.valid && acc.write && acc.offset == OFS_PAT_DET1) |=> $stable(cfg[acc.framer]))
    else $error("read-only write changed state");
  AST_RD_LAT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && HREADY && next_valid && !HWRITE) |=> !HREADYOUT ##1 (CLK_EN ? HREADYOUT : 1'b1))
    else $error("read not answered in two cycles");
  AST_UNUSED_ZERO: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    HRDATA[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  AST_STATUS_SET: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && evt_s2[3] && !evt_d[3]) |=> (cfg[3].irq[7] && $stable(cfg[2].irq[7])))
    else $error("status event not confined to its framer");
  // Frozen clock enable must hold framer 2 config, HREADYOUT and HRDATA
  AST_FREEZE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !CLK_EN |=> ($stable(cfg[2]) && $stable(HREADYOUT) && $stable(HRDATA)))
    else $error("state moved while clock enable low");

  COV_FREEZE: cover property (@(posedge CORE_CLK) !CLK_EN && !SYS_RST);
  COV_WRITE: cover property (@(posedge CORE_CLK) acc.valid && acc.write);
  COV_READ:  cover property (@(posedge CORE_CLK) rd_wait && HREADYOUT == 1'b0);
  COV_TEST:  cover property (@(posedge CORE_CLK) TEST_HIT);

endmodule
`default_nettype wire

// ==== design/ofrd_pkg.sv ====
package ofrd_pkg;

  // ----------------------------------------------------------------
  // Address layout
  // ----------------------------------------------------------------
  localparam int          NUM_FRAMERS   = 8;
  localparam int          ADDR_W        = 11;
  localparam int          TEST_SEL_BIT  = 10;
  localparam int          FRM_SEL_HI    = 9;
  localparam int          FRM_SEL_LO    = 7;
  localparam int          REG_SEL_HI    = 6;
  localparam logic [10:0] FRAMER_STRIDE = 11'h080;
  localparam int          HADDR_IDX_LO  = 2;

  // ----------------------------------------------------------------
  // Register offsets within one framer
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_BOC_CODE  = 7'h5D;
  localparam logic [6:0] OFS_PAT_CTRL  = 7'h60;
  localparam logic [6:0] OFS_PAT_IRQ   = 7'h61;
  localparam logic [6:0] OFS_PAT_LEN   = 7'h62;
  localparam logic [6:0] OFS_PAT_TAP   = 7'h63;
  localparam logic [6:0] OFS_PAT_ERR   = 7'h64;
  localparam logic [6:0] OFS_PAT_INS1  = 7'h68;
  localparam logic [6:0] OFS_PAT_INS2  = 7'h69;
  localparam logic [6:0] OFS_PAT_INS3  = 7'h6A;
  localparam logic [6:0] OFS_PAT_INS4  = 7'h6B;
  localparam logic [6:0] OFS_PAT_DET1  = 7'h6C;
  localparam logic [6:0] OFS_PAT_DET2  = 7'h6D;
  localparam logic [6:0] OFS_PAT_DET3  = 7'h6E;
  localparam logic [6:0] OFS_PAT_DET4  = 7'h6F;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BOC_CODE_MASK = 8'h3F;
  localparam logic [7:0] IRQ_WR_MASK   = 8'h03;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] UNUSED_READ   = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic [7:0] boc_code;
    logic [7:0] ctrl;
    logic [7:0] irq;
    logic [7:0] len;
    logic [7:0] tap;
    logic [7:0] err;
    logic [7:0] ins1;
    logic [7:0] ins2;
    logic [7:0] ins3;
    logic [7:0] ins4;
  } ofrd_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] framer;
    logic [6:0] offset;
  } ofrd_acc_t;

endpackage

// ==== dv/ofrd_framer_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Framer-side model: pattern engine loopback
// ----------------------------------------
module ofrd_framer_model
  import ofrd_pkg::*;
(
  input  wire logic                      clk,         // Core clock
  input  wire logic [NUM_FRAMERS*80-1:0] cfg,         // Programmed settings
  input  wire logic [NUM_FRAMERS-1:0]    fire,        // Bench event request
  output logic      [NUM_FRAMERS*32-1:0] det_pattern, // Detected bytes
  output logic      [NUM_FRAMERS-1:0]    det_event    // Status pulses
);
  // Inserted pattern comes back inverted, so a stuck path cannot match
  always_ff @(posedge clk) begin
    for (int f = 0; f < NUM_FRAMERS; f++) begin
      for (int n = 0; n < 4; n++) begin
        det_pattern[f*32+n*8 +: 8] <= ~cfg[f*80+24-n*8 +: 8];
      end
    end
    det_event <= fire;
  end
endmodule
`default_nettype wire

// ==== dv/test_octal_framer_register_decode.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_octal_framer_register_decode;
  import ofrd_pkg::*;
  logic                      CORE_CLK = 1'b0, SYS_RST = 1'b1, CLK_EN = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
  logic [31:0]               HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
  logic [1:0]                HTRANS = 2'h0;
  logic [2:0]                HSIZE = HSIZE_WORD;
  logic                      HREADYOUT, HRESP, TEST_HIT;
  logic [NUM_FRAMERS*32-1:0] det_pattern;
  logic [NUM_FRAMERS-1:0]    det_event, fire = 8'h00;
  logic [NUM_FRAMERS*80-1:0] CFG_OUT;
  logic [6:0]                ofs [10] = '{7'h5D, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64, 7'h68, 7'h69, 7'h6A, 7'h6B};
  int                        fails = 0, samples_checked = 0, cycles = 0;

  always #50 CORE_CLK = ~CORE_CLK;

  ofrd_regs dut (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .DET_PATTERN(det_pattern), .DET_EVENT(det_event), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .CFG_OUT(CFG_OUT), .TEST_HIT(TEST_HIT));
  ofrd_framer_model model (.clk(CORE_CLK), .cfg(CFG_OUT), .fire(fire), .det_pattern(det_pattern),
    .det_event(det_event));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One single word transfer; waits for the slave without assuming latency
  task automatic bus(input logic wr, input logic [10:0] idx, input logic [31:0] wd, output logic [31:0] r);
    HSEL <= 1'b1;
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= wr;
    HADDR <= {19'h0, idx, 2'h0};
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask

  function automatic logic [7:0] wv(input int f, input int k);
    return 8'(f * 16 + k + 8'h31);
  endfunction

  function automatic logic [7:0] msk(input int k);
    return (k == 0) ? 8'h3F : (k == 2) ? 8'h03 : 8'hFF;
  endfunction

  function automatic logic [10:0] ix(input int f, input logic [6:0] o);
    return 11'(FRAMER_STRIDE * 11'(f)) + {4'h0, o};
  endfunction

  task automatic t_reset();
    SYS_RST <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    @(posedge CORE_CLK);
    check("cfg_out", CFG_OUT[31:0] | CFG_OUT[639:608], 32'h0);
    for (int f = 0; f < NUM_FRAMERS; f++) begin
      for (int k = 0; k < 10; k++) begin
        bus(1'b0, ix(f, ofs[k]), 32'h0, rd);
        check("reset_value", rd, 32'h0);
      end
    end
    $display("test reset done");
  endtask

  task automatic t_rw();
    for (int f = 0; f < NUM_FRAMERS; f++) begin
      for (int k = 0; k < 10; k++) begin
        bus(1'b1, ix(f, ofs[k]), {24'hFFFFFF, wv(f, k)}, rd);
      end
    end
    for (int f = 0; f < NUM_FRAMERS; f++) begin
      for (int k = 0; k < 10; k++) begin
        bus(1'b0, ix(f, ofs[k]), 32'h0, rd);
        check("readback", rd, {24'h0, wv(f, k) & msk(k)});
      end
      check("cfg_boc", {24'h0, CFG_OUT[f*80+72 +: 8]}, {24'h0, wv(f, 0) & 8'h3F});
    end
    $display("test readback done");
  endtask

  task automatic t_ro();
    repeat (8) @(posedge CORE_CLK);
    for (int f = 0; f < NUM_FRAMERS; f++) begin
      for (int n = 0; n < 4; n++) begin
        bus(1'b1, ix(f, 7'(7'h6C + n)), 32'hFFFFFF5A, rd);
        bus(1'b0, ix(f, 7'(7'h6C + n)), 32'h0, rd);
        check("detector", rd, {24'h0, ~wv(f, 6 + n)});
      end
      check("cfg_ins", CFG_OUT[f*80 +: 32], {wv(f, 6), wv(f, 7), wv(f, 8), wv(f, 9)});
      bus(1'b1, ix(f, 7'h5E), 32'hFFFFFFFF, rd);
      bus(1'b0, ix(f, 7'h5E), 32'h0, rd);
      check("unmapped", rd, 32'h0);
    end
    $display("test read-only done");
  endtask

  task automatic t_test_space();
    bus(1'b1, 11'h45D, 32'h00000015, rd);
    bus(1'b0, 11'h45D, 32'h0, rd);
    check("test_read", rd, 32'h0);
    check("test_hit", {31'h0, TEST_HIT}, 32'h1);
    bus(1'b0, 11'h05D, 32'h0, rd);
    check("normal_kept", rd, {24'h0, wv(0, 0) & 8'h3F});
    check("test_hit_low", {31'h0, TEST_HIT}, 32'h0);
    $display("test test-space done");
  endtask

  task automatic t_event();
    fire <= 8'h08;
    @(posedge CORE_CLK);
    fire <= 8'h00;
    repeat (8) @(posedge CORE_CLK);
    bus(1'b0, ix(3, 7'h61), 32'h0, rd);
    check("status_set", rd, {24'h0, 8'h80 | (wv(3, 2) & 8'h03)});
    bus(1'b0, ix(2, 7'h61), 32'h0, rd);
    check("status_other", rd, {24'h0, wv(2, 2) & 8'h03});
    bus(1'b1, ix(3, 7'h61), {24'h0, 8'h80 | wv(3, 2)}, rd);
    bus(1'b0, ix(3, 7'h61), 32'h0, rd);
    check("status_clear", rd, {24'h0, wv(3, 2) & 8'h03});
    CLK_EN <= 1'b0;
    fire   <= 8'h04;
    @(posedge CORE_CLK);
    fire <= 8'h00;
    repeat (4) @(posedge CORE_CLK);
    CLK_EN <= 1'b1;
    @(posedge CORE_CLK);
    bus(1'b0, ix(2, 7'h61), 32'h0, rd);
    check("status_frozen", rd, {24'h0, wv(2, 2) & 8'h03});
    $display("test status done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 10000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    t_reset();
    t_rw();
    t_ro();
    t_test_space();
    t_event();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
